// ==== testbench.sv ====
// Self-checking bench for the write leveling feedback block.
// Assumes the checker binds itself from its own file.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import wlv_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic org_x16_pin = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic ck_pin, odt_pin, strobe_lower_pin, strobe_upper_pin;
    logic [DQ_W-1:0] dq_out, dq_oe;
    logic strobe_rx_on, strobe_term_on, dq_term_on;
    int err_count = 0;
    int samples_checked = 0;

    always #12.5 clk = ~clk;

    wlv_feedback DUT (
        .clk(clk),
        .reset(reset),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .ck_pin(ck_pin),
        .odt_pin(odt_pin),
        .org_x16_pin(org_x16_pin),
        .strobe_lower_pin(strobe_lower_pin),
        .strobe_upper_pin(strobe_upper_pin),
        .dq_out(dq_out),
        .dq_oe(dq_oe),
        .strobe_rx_on(strobe_rx_on),
        .strobe_term_on(strobe_term_on),
        .dq_term_on(dq_term_on)
    );
    wlv_ctrl_model ctrl (
        .ck_pin(ck_pin),
        .odt_pin(odt_pin),
        .strobe_lower_pin(strobe_lower_pin),
        .strobe_upper_pin(strobe_upper_pin)
    );

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (8) @(posedge clk);
        // Leave the edge so callers compare settled outputs
        #1;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp, "read");
    endtask

    // Both lanes share one layout: samples low, state, enables, strap
    function automatic logic [DATA_W-1:0] status(input logic en, input logic x16,
        input logic [1:0] smp);
        return {9'h000, x16, en, 1'b1, 2'h2, smp};
    endfunction

    function automatic logic ck_expect(input int off);
        return off < 100;
    endfunction

    task automatic strobe_and_check(input bit up, input int off, input logic [DQ_W-1:0] exp);
        ctrl.pulse(up, off);
        check(dq_out, exp, "feedback");
    endtask

    initial begin
        logic [DATA_W-1:0] mr [MODE_REG_COUNT];
        int off;
        void'($urandom(33));
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        check({dq_oe, strobe_rx_on, strobe_term_on, dq_term_on}, 0, "reset");
        rd(MODE_REG_1_IDX, MODE_REG_RESET);
        for (int i = 0; i < MODE_REG_COUNT; i++) begin
            mr[i] = (i == 1) ? 16'h0004 : 16'(($urandom % 16'hffff));
            wr(3'(i), mr[i]);
        end
        for (int i = 0; i < MODE_REG_COUNT; i++) rd(3'(i), mr[i]);
        wr(3'h5, 16'hffff);
        rd(3'h5, 16'h0000);
        wr(MODE_REG_1_IDX, 16'h0084);
        check({dq_oe, strobe_rx_on, strobe_term_on, dq_term_on}, 19'h007fc, "enter");
        ctrl.set_odt(1'b1);
        repeat (8) @(posedge clk);
        check({strobe_term_on, dq_term_on}, 2'b10, "odt on");
        for (int i = 0; i < 12; i++) begin
            off = (i == 0) ? 30 : (i == 1) ? 170 : 30 + int'($urandom % 41) + int'($urandom % 2) * 100;
            strobe_and_check(0, off, {15'h0, ck_expect(off)});
        end
        rd(STATUS_IDX, status(1'b1, 1'b0, {1'b0, ck_expect(off)}));
        // Sweep the strobe delay until the feedback turns from 0 to 1, then freeze it.
        // Sync quantisation lets the found delay lead the CK rise by up to one clk period.
        off = 110;
        ctrl.pulse(0, off);
        while (dq_out[PRIME_BIT] !== 1'b1 && off < 260) begin
            off += 10;
            ctrl.pulse(0, off);
        end
        check(off > 175 && off <= 200, 1, "sweep");
        @(posedge clk);
        org_x16_pin <= 1'b1;
        repeat (8) @(posedge clk);
        check(dq_oe, 16'hffff, "x16 drive");
        strobe_and_check(0, 40, 16'h0001);
        strobe_and_check(1, 150, 16'h0001);
        strobe_and_check(1, 50, 16'h0101);
        strobe_and_check(0, 160, 16'h0100);
        rd(STATUS_IDX, status(1'b1, 1'b1, 2'b10));
        wr(MODE_REG_1_IDX, 16'h1284);
        check({dq_oe, strobe_rx_on, strobe_term_on, dq_term_on}, 20'h00002, "qoff");
        ctrl.pulse(0, 40);
        check({dq_oe, strobe_rx_on}, 0, "qoff strobe");
        ctrl.set_odt(1'b0);
        repeat (8) @(posedge clk);
        check(strobe_term_on, 0, "odt off");
        wr(MODE_REG_1_IDX, 16'h0000);
        check({dq_oe, strobe_rx_on}, 0, "exit");
        tally_and_finish();
    end

    initial begin
        #100000;
        err_count++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        tally_and_finish();
    end
endmodule

// ==== wlv_ctrl_model.sv ====
// Controller stand-in: free-running CK, ODT and two strobes parked low.
// Assumes one caller of its tasks at a time.
module wlv_ctrl_model (
    // Memory side pins
    output logic ck_pin,
    output logic odt_pin,
    output logic strobe_lower_pin,
    output logic strobe_upper_pin
);
    timeunit 1ns;
    timeprecision 100ps;

    // Data lines never driven, no commands sent
    initial begin
        ck_pin = 1'b0;
        odt_pin = 1'b0;
        strobe_lower_pin = 1'b0;
        strobe_upper_pin = 1'b0;
        #7;
        forever #100 ck_pin = ~ck_pin;
    end

    // Caller waits well past the mode update delay before this
    task automatic set_odt(input logic v);
        odt_pin <= v;
    endtask

    // Offset is the strobe delay under trial after a CK rise; widths far above minimum
    task automatic pulse(input bit upper, input int off);
        @(posedge ck_pin);
        #(off);
        if (upper) strobe_upper_pin = 1'b1;
        else strobe_lower_pin = 1'b1;
        #150;
        strobe_lower_pin = 1'b0;
        strobe_upper_pin = 1'b0;
        #150;
    endtask
endmodule

// ==== wlv_feedback.sv ====
// Write leveling feedback of a DDR3 memory device: mode registers, termination
// control and the per-lane feedback on the prime data lines.
// Assumes clock, strobe, ODT and organisation pins arrive asynchronous to clk.
//
// The strobed register port and the address map are this design's own decisions.

module wlv_feedback
    import wlv_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Memory side inputs
    input wire logic ck_pin,
    input wire logic odt_pin,
    input wire logic org_x16_pin,
    input wire logic strobe_lower_pin,
    input wire logic strobe_upper_pin,
    // Data lines
    output logic [DQ_W-1:0] dq_out,
    output logic [DQ_W-1:0] dq_oe,
    // Buffer and termination control
    output logic strobe_rx_on,
    output logic strobe_term_on,
    output logic dq_term_on
);
    import wlv_pkg::*;

    logic [SYNC_PINS-1:0] pin_meta;
    logic [SYNC_PINS-1:0] pin_sync;
    logic ck_level;
    logic odt_level;
    logic org_x16;

    logic [DATA_W-1:0] mode_reg [MODE_REG_COUNT];
    logic [DATA_W-1:0] mr1_active;
    logic [DELAY_CNT_W-1:0] update_cnt;
    logic update_pending;

    logic level_on;
    logic outputs_on;
    logic rtt_set;
    logic [LANES-1:0] lane_used;
    logic [LANES-1:0] lane_sample;
    logic [LANES-1:0] lane_published;
    logic capture_en;

    wlv_state_t state;
    wlv_state_t next_state;

    // Pins from the memory side, two stages before use
    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= {org_x16_pin, odt_pin, ck_pin};
            pin_sync <= pin_meta;
        end
    end

    assign ck_level = pin_sync[PIN_CK];
    assign odt_level = pin_sync[PIN_ODT];
    assign org_x16 = pin_sync[PIN_X16];

    // Mode registers, written by the mode register set port
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < MODE_REG_COUNT; i++) begin
                mode_reg[i] <= MODE_REG_RESET;
            end
        end else if (reg_wr && reg_addr < ADDR_W'(MODE_REG_COUNT)) begin
            mode_reg[reg_addr[1:0]] <= reg_wdata;
        end
    end

    // A new mode register 1 value takes effect only after the update delay
    always_ff @(posedge clk) begin
        if (reset) begin
            update_pending <= 1'b0;
            update_cnt <= '0;
        end else if (reg_wr && reg_addr == MODE_REG_1_IDX) begin
            update_pending <= 1'b1;
            update_cnt <= DELAY_CNT_W'(MODE_UPDATE_DELAY_CYC - 1);
        end else if (update_pending && update_cnt != '0) begin
            update_cnt <= update_cnt - DELAY_CNT_W'(1);
        end else begin
            update_pending <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mr1_active <= MODE_REG_RESET;
        end else if (update_pending && update_cnt == '0) begin
            mr1_active <= mode_reg[MODE_REG_1_IDX[1:0]];
        end
    end

    // Decoded mode fields
    assign level_on = mr1_active[MR1_LEVEL_BIT];
    assign outputs_on = !mr1_active[MR1_QOFF_BIT];
    // Any nonzero termination code is accepted; limiting it is the controller's task
    assign rtt_set = mr1_active[MR1_RTT_BIT0] || mr1_active[MR1_RTT_BIT1]
        || mr1_active[MR1_RTT_BIT2];
    assign lane_used = {org_x16, 1'b1};

    // Strobe receivers capture only with outputs enabled
    assign capture_en = level_on && outputs_on;

    // Leveling sequence state
    always_comb begin
        next_state = state;
        case (state)
            WLV_OFF: begin
                if (level_on) begin
                    next_state = WLV_ARMED;
                end
            end
            WLV_ARMED: begin
                if (!level_on) begin
                    next_state = WLV_OFF;
                end else if (|(lane_published & lane_used)) begin
                    next_state = WLV_REPORT;
                end
            end
            WLV_REPORT: begin
                if (!level_on) begin
                    next_state = WLV_OFF;
                end
            end
            default: begin
                next_state = WLV_OFF;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= WLV_OFF;
        end else begin
            state <= next_state;
        end
    end

    // One capture unit per byte lane, each leveled on its own strobe
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : gen_lane
            wlv_lane_if lane_link ();
            wlv_lane u_lane (
                .clk(clk),
                .reset(reset),
                .lane_if(lane_link.lane)
            );
            assign lane_link.strobe_pin = (g == 0) ? strobe_lower_pin : strobe_upper_pin;
            assign lane_link.ck_level = ck_level;
            assign lane_link.capture_en = capture_en && lane_used[g];
            assign lane_sample[g] = lane_link.sample;
            assign lane_published[g] = lane_link.published;
        end
    endgenerate

    // Data lines: prime bit carries the feedback, the rest are held low.
    // Lines are driven from leveling entry, so the non-prime lines are low
    // well before the first feedback appears.
    always_ff @(posedge clk) begin
        if (reset) begin
            dq_out <= '0;
            dq_oe <= '0;
        end else begin
            for (int l = 0; l < LANES; l++) begin
                for (int b = 0; b < LANE_W; b++) begin
                    if (b == PRIME_BIT && state == WLV_REPORT) begin
                        dq_out[l*LANE_W+b] <= lane_sample[l];
                    end else begin
                        dq_out[l*LANE_W+b] <= 1'b0;
                    end
                    dq_oe[l*LANE_W+b] <= capture_en && lane_used[l];
                end
            end
        end
    end

    // Termination and strobe receiver control
    always_ff @(posedge clk) begin
        if (reset) begin
            strobe_rx_on <= 1'b0;
            strobe_term_on <= 1'b0;
            dq_term_on <= 1'b0;
        end else if (level_on) begin
            strobe_rx_on <= outputs_on;
            strobe_term_on <= odt_level && rtt_set;
            dq_term_on <= 1'b0;
        end else begin
            strobe_rx_on <= 1'b0;
            strobe_term_on <= odt_level && rtt_set;
            dq_term_on <= odt_level && rtt_set;
        end
    end

    // Read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_rd && reg_addr < ADDR_W'(MODE_REG_COUNT)) begin
            reg_rdata <= mode_reg[reg_addr[1:0]];
        end else if (reg_rd && reg_addr == STATUS_IDX) begin
            reg_rdata <= {{(DATA_W-STATUS_USED_W){1'b0}}, org_x16, outputs_on,
                level_on, state, lane_sample};
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

// ==== wlv_feedback_checker.sv ====
// Assertions on the pins of the write leveling feedback block.
// Assumes MR1 changes only through register writes at its index.
module wlv_feedback_checker
    import wlv_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic reset,
    // Register port
    input wire logic [wlv_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [wlv_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    // Memory side
    input wire logic ck_pin,
    input wire logic odt_pin,
    input wire logic org_x16_pin,
    input wire logic strobe_lower_pin,
    // Outputs
    input wire logic [wlv_pkg::DQ_W-1:0] dq_out,
    input wire logic [wlv_pkg::DQ_W-1:0] dq_oe,
    input wire logic strobe_rx_on,
    input wire logic strobe_term_on,
    input wire logic dq_term_on
);
    logic [DATA_W-1:0] mr1;
    logic [3:0] quiet;
    logic [3:0] lo_age;
    logic odt_prev, org_prev, lo_prev, ck_cap;
    wire mr1_wr = reg_wr && reg_addr == MODE_REG_1_IDX;
    // Pins pass synchronisers, so only judge once ODT, the strap pin and MR1 writes have been still for ten clocks
    // A pin that moved since the last edge is not yet seen inside, so it is not settled
    wire settled = quiet >= 4'ha && odt_pin == odt_prev && org_x16_pin == org_prev;
    wire lvl = settled && mr1[MR1_LEVEL_BIT];
    wire lvl_on = lvl && !mr1[MR1_QOFF_BIT];
    wire rtt = mr1[MR1_RTT_BIT0] | mr1[MR1_RTT_BIT1] | mr1[MR1_RTT_BIT2];

    always_ff @(posedge clk) begin
        if (reset) mr1 <= MODE_REG_RESET;
        else if (mr1_wr) mr1 <= reg_wdata;
    end

    always_ff @(posedge clk) begin
        odt_prev <= odt_pin;
        org_prev <= org_x16_pin;
        if (reset || mr1_wr || odt_pin != odt_prev || org_x16_pin != org_prev) quiet <= 4'h0;
        else if (quiet != 4'hf) quiet <= quiet + 4'h1;
    end

    always_ff @(posedge clk) begin
        lo_prev <= strobe_lower_pin;
        if (reset) lo_age <= 4'hf;
        else if (strobe_lower_pin && !lo_prev) begin
            ck_cap <= ck_pin;
            lo_age <= 4'h0;
        end else if (lo_age != 4'hf) lo_age <= lo_age + 4'h1;
    end

    sequence lower_edge_s;
        $rose(strobe_lower_pin) && lvl_on;
    endsequence

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    reset_quiet_a: assert property (disable iff (1'b0) reset |=>
        dq_oe == '0 && !strobe_rx_on && !strobe_term_on && !dq_term_on) else $error("active after reset");
    qoff_quiet_a: assert property (settled && mr1[MR1_QOFF_BIT] |->
        dq_oe == '0 && !strobe_rx_on) else $error("outputs disabled yet active");
    level_off_a: assert property (settled && !mr1[MR1_LEVEL_BIT] |-> dq_oe == '0)
        else $error("driving with leveling off");
    dq_term_a: assert property (lvl |-> !dq_term_on)
        else $error("data termination on");
    strobe_term_a: assert property (lvl |-> strobe_term_on == (odt_pin && rtt))
        else $error("strobe termination wrong");
    lane_drive_a: assert property (lvl_on |-> strobe_rx_on &&
        dq_oe == (org_x16_pin ? 16'hffff : 16'h00ff)) else $error("lane drive wrong");
    low_lines_a: assert property (|dq_oe |-> (dq_out & 16'hfefe) == 16'h0000)
        else $error("non-prime line high");
    prime_report_a: assert property (lower_edge_s |-> ##7 dq_out[PRIME_BIT] == ck_cap)
        else $error("prime sample wrong");
    prime_hold_a: assert property (dq_out[PRIME_BIT] != $past(dq_out[PRIME_BIT])
        && dq_oe[PRIME_BIT] && $past(dq_oe[PRIME_BIT]) |-> lo_age <= 4'h8) else $error("prime moved");
endmodule

bind wlv_feedback wlv_feedback_checker chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .ck_pin(ck_pin), .odt_pin(odt_pin),
    .org_x16_pin(org_x16_pin), .strobe_lower_pin(strobe_lower_pin), .dq_out(dq_out),
    .dq_oe(dq_oe), .strobe_rx_on(strobe_rx_on), .strobe_term_on(strobe_term_on),
    .dq_term_on(dq_term_on));

// ==== wlv_lane.sv ====
// Strobe capture for one byte lane: finds rising strobe edges, samples the clock level.
// Assumes ck_level was synchronised with the same two-stage depth as the strobe here.
module wlv_lane
    import wlv_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic reset,
    // Controller side
    wlv_lane_if.lane lane_if
);
    import wlv_pkg::*;

    logic strobe_meta;
    logic strobe_sync;
    logic strobe_prev;
    logic pending;
    logic pending_level;
    logic [DELAY_CNT_W-1:0] delay_cnt;
    logic rise;

    always_ff @(posedge clk) begin
        if (reset) begin
            strobe_meta <= 1'b0;
            strobe_sync <= 1'b0;
            strobe_prev <= 1'b0;
        end else begin
            strobe_meta <= lane_if.strobe_pin;
            strobe_sync <= strobe_meta;
            strobe_prev <= strobe_sync;
        end
    end

    assign rise = strobe_sync && !strobe_prev;

    // Same sync depth on clock and strobe keeps their relative phase
    always_ff @(posedge clk) begin
        if (reset) begin
            pending <= 1'b0;
            pending_level <= 1'b0;
            delay_cnt <= '0;
        end else if (!lane_if.capture_en) begin
            pending <= 1'b0;
            delay_cnt <= '0;
        end else if (rise) begin
            pending <= 1'b1;
            pending_level <= lane_if.ck_level;
            delay_cnt <= DELAY_CNT_W'(LEVELING_OUTPUT_DELAY_CYC - 1);
        end else if (pending && delay_cnt != '0) begin
            delay_cnt <= delay_cnt - DELAY_CNT_W'(1);
        end else if (pending) begin
            pending <= 1'b0;
        end
    end

    // Feedback clears while capture is disabled, else holds until the next capture is published
    always_ff @(posedge clk) begin
        if (reset) begin
            lane_if.sample <= 1'b0;
            lane_if.published <= 1'b0;
        end else begin
            lane_if.published <= 1'b0;
            if (!lane_if.capture_en) begin
                lane_if.sample <= 1'b0;
            end else if (pending && delay_cnt == '0 && !rise) begin
                lane_if.sample <= pending_level;
                lane_if.published <= 1'b1;
            end
        end
    end

endmodule

// ==== wlv_lane_if.sv ====
// Signals between the leveling controller and one byte lane's strobe capture.
// Assumes both ends run on the same system clock.
interface wlv_lane_if;
    logic strobe_pin;
    logic ck_level;
    logic capture_en;
    logic sample;
    logic published;

    modport lane (
        input strobe_pin,
        input ck_level,
        input capture_en,
        output sample,
        output published
    );
    modport ctrl (
        output strobe_pin,
        output ck_level,
        output capture_en,
        input sample,
        input published
    );
endinterface

// ==== wlv_pkg.sv ====
// Constants, field layouts and types shared by the write leveling feedback logic.
// Assumes a single 40 MHz system clock that samples every pin of the memory side.
package wlv_pkg;

    // Clock and times
    localparam int CLK_PERIOD_PS = 25000;
    // Longest time from a captured strobe edge to the feedback level
    localparam int LEVELING_OUTPUT_DELAY_PS = 7500;
    localparam int LEVELING_OUTPUT_DELAY_CYC =
        (LEVELING_OUTPUT_DELAY_PS / CLK_PERIOD_PS < 1) ? 1
        : LEVELING_OUTPUT_DELAY_PS / CLK_PERIOD_PS;
    // Least time before a mode register write takes effect
    localparam int MODE_UPDATE_DELAY_PS = 15000;
    localparam int MODE_UPDATE_DELAY_CYC =
        ((MODE_UPDATE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS < 1) ? 1
        : (MODE_UPDATE_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DELAY_CNT_W = 4;

    // Register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 16;
    localparam int MODE_REG_COUNT = 4;
    localparam logic [ADDR_W-1:0] MODE_REG_1_IDX = 3'h1;
    localparam logic [ADDR_W-1:0] STATUS_IDX = 3'h4;
    localparam logic [DATA_W-1:0] MODE_REG_RESET = 16'h0000;

    // Fields of mode register 1
    localparam int MR1_LEVEL_BIT = 7;
    localparam int MR1_QOFF_BIT = 12;
    localparam int MR1_RTT_BIT0 = 2;
    localparam int MR1_RTT_BIT1 = 6;
    localparam int MR1_RTT_BIT2 = 9;

    // Data lanes
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int DQ_W = LANES * LANE_W;
    localparam int PRIME_BIT = 0;
    localparam int SYNC_PINS = 3;
    localparam int PIN_CK = 0;
    localparam int PIN_ODT = 1;
    localparam int PIN_X16 = 2;

    // Status register layout, low bits upward
    localparam int STATUS_USED_W = 7;

    typedef enum logic [1:0] {
        WLV_OFF = 2'b00,
        WLV_ARMED = 2'b01,
        WLV_REPORT = 2'b10
    } wlv_state_t;

endpackage
